//--- dv/serial_host_model.sv
// Purpose: Controller model driving the four-wire command port
// Assumes: Eight sys_clk cycles per serial clock phase, well above the sampling minimum
// Notes: Serial clock rests low between frames; data line toggles when released
`timescale 1ns/1ps
`default_nettype none
module serial_host_model (
    input  wire logic sys_clk,
    output logic      chip_select_low,
    output logic      serial_clock,
    output logic      serial_in,
    input  wire logic serial_out,
    input  wire logic serial_out_en
);
    initial begin
        chip_select_low = 1'b1;
        serial_clock    = 1'b0;
        serial_in       = 1'b0;
    end

    task automatic half;
        repeat (8) @(posedge sys_clk);
    endtask : half

    task automatic send(input logic b);
        serial_in <= b;
        half();
        serial_clock <= 1'b1;
        half();
        serial_clock <= 1'b0;
    endtask : send

    // One register per frame; the don't-care header bit is sent as 1 on purpose
    task automatic xfer(input logic rd_op, input logic [3:0] adr, input logic [7:0] wdata,
                        output logic [4:0] rdata, output logic en_ok);
        logic [7:0] hdr;
        hdr = {1'b1, 2'b00, adr, rd_op};
        rdata = 5'h00;
        en_ok = 1'b1;
        chip_select_low <= 1'b0;
        half();
        for (int i = 0; i < 8; i++) send(hdr[i]);
        if (rd_op) begin
            for (int i = 0; i < 5; i++) begin
                serial_in <= ~serial_in;
                half();
                rdata[i] = serial_out;
                en_ok &= serial_out_en;
                serial_clock <= 1'b1;
                half();
                serial_clock <= 1'b0;
            end
            half();
            en_ok &= ~serial_out_en;
        end else begin
            for (int i = 0; i < 8; i++) send(wdata[i]);
            half();
        end
        chip_select_low <= 1'b1;
        serial_in <= ~serial_in;
        half();
    endtask : xfer
endmodule : serial_host_model
`default_nettype wire

//--- dv/synth_command_registers_chk.sv
// Purpose: Assertions on the command register bank ports
// Assumes: Single clock domain, synchronous reset
// Notes: Bound to every instance of the bank
`timescale 1ns/1ps
`default_nettype none
module synth_command_registers_chk
    import synth_cmd_pkg::*;
(
    input wire logic                              sys_clk,
    input wire logic                              rst,
    input wire logic                              chip_select_low,
    input wire logic                              serial_clock,
    input wire logic                              serial_in,
    input wire logic                              serial_out,
    input wire logic                              serial_out_en,
    input wire logic                              slave_config,
    input wire synth_cmd_pkg::operating_mode_code_type operating_mode_code,
    input wire synth_cmd_pkg::mode_decode_type    mode_decode,
    input wire synth_cmd_pkg::synth_control_type  synth_control
);
    import synth_cmd_pkg::*;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    AST_FWD_T1: assert property (!slave_config && operating_mode_code inside {4'h0, 4'h1, 4'h2}
        |-> mode_decode.fwd_family && mode_decode.ref_kind == ref_n_t1) else $error("fwd t1 decode");
    AST_FWD_E1: assert property (!slave_config && operating_mode_code inside {4'h4, 4'h5, 4'h6}
        |-> mode_decode.fwd_family && mode_decode.ref_kind == ref_n_e1) else $error("fwd e1 decode");
    AST_REVERSE: assert property (!slave_config && operating_mode_code inside {4'h3, 4'h7}
        |-> mode_decode.out1_kind == out_t1 && mode_decode.out2_kind == out_e1
        && mode_decode.ref_kind == (operating_mode_code == 4'h3 ? ref_56k : ref_64k))
        else $error("reverse decode");
    AST_E1_TO_T1: assert property (!slave_config && operating_mode_code == 4'h8
        |-> mode_decode.out1_kind == out_t1 && mode_decode.out2_kind == out_t1) else $error("e1 t1");
    AST_HIGH_SPEED: assert property (operating_mode_code == 4'hD |-> mode_decode.high_speed
        && mode_decode.ref_kind == ref_64k && mode_decode.out2_kind == out_m_e1) else $error("hs");
    AST_FRAC: assert property (!slave_config && operating_mode_code inside {[4'h9:4'hC]}
        |-> mode_decode.frac_family && mode_decode.ref_kind
        == (operating_mode_code < 4'hB ? ref_p_56k : ref_p_64k)) else $error("frac decode");
    AST_SLAVE_REF: assert property (slave_config && operating_mode_code <= 4'hC
        |-> mode_decode.ref_kind == ref_8k) else $error("slave reference");
    AST_M_PASS: assert property (mode_decode.high_speed && synth_control.out1_factor
        inside {5'h01, 5'h02, 5'h04, 5'h08} |-> synth_control.out1_multiple_m
        == synth_control.out1_factor) else $error("multiplier m");
    AST_HOLD: assert property (chip_select_low && $past(chip_select_low) |->
        $stable({operating_mode_code, synth_control.out1_factor, synth_control.out2_factor}))
        else $error("moved while idle");
    AST_IDLE_OUT: assert property (chip_select_low && $past(chip_select_low, 4)
        |-> !serial_out_en) else $error("driven while idle");
    AST_OUT_HOLD: assert property (serial_out_en && serial_clock && $past(serial_clock, 3)
        |-> $stable(serial_out)) else $error("read bit moved");
endmodule : synth_command_registers_chk
bind synth_command_registers synth_command_registers_chk synth_command_registers_chk_inst (.*);
`default_nettype wire

//--- dv/synth_command_registers_tb.sv
// Purpose: Self-checking bench for the command register bank
// Assumes: 25 MHz clock, reset held 16 cycles
// Notes: Serial traffic comes from the controller model
`timescale 1ns/1ps
`default_nettype none
module synth_command_registers_tb;
    import synth_cmd_pkg::*;
    logic                    sys_clk = 1'b0;
    logic                    rst = 1'b1;
    logic                    slave_config = 1'b0;
    wire logic               chip_select_low;
    wire logic               serial_clock;
    wire logic               serial_in;
    logic                    serial_out;
    logic                    serial_out_en;
    operating_mode_code_type operating_mode_code;
    mode_decode_type         mode_decode;
    synth_control_type       synth_control;
    int                      errors = 0;
    int                      num_checks = 0;
    logic [4:0]              rd;
    logic                    ok;
    localparam logic [2:0] REF_M [14] = '{3'h0, 3'h0, 3'h0, 3'h2, 3'h1, 3'h1, 3'h1,
                                          3'h3, 3'h1, 3'h4, 3'h4, 3'h5, 3'h5, 3'h3};
    localparam logic [2:0] OUT1_M [14] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h0, 3'h0, 3'h1,
                                           3'h2, 3'h2, 3'h2, 3'h2, 3'h3, 3'h3, 3'h4};
    localparam logic [4:0] VALS [8] = '{5'h07, 5'h1B, 5'h1F, 5'h11, 5'h1C, 5'h15, 5'h0A, 5'h13};

    always #20 sys_clk = ~sys_clk;

    synth_command_registers synth_command_registers_inst (.*);
    serial_host_model serial_host_model_inst (.*);

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        num_checks++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%0h exp=%0h", $time, seen, exp);
        end
    endtask : check

    task automatic conclude;
        $display("checks=%0d errors=%0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : conclude

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        serial_host_model_inst.xfer(1'b0, a, d, rd, ok);
    endtask : wr

    task automatic rdreg(input logic [3:0] a);
        serial_host_model_inst.xfer(1'b1, a, 8'h00, rd, ok);
    endtask : rdreg

    // Second pass writes the complement so every bit is seen both ways
    task automatic t_regs;
        logic [4:0] v [8];
        for (int p = 0; p < 2; p++) begin
            for (int i = 0; i < 8; i++) begin
                v[i] = p ? ~VALS[i] : VALS[i];
                wr(4'(i), {3'h0, v[i]});
            end
            for (int i = 0; i < 8; i++) begin
                rdreg(4'(i));
                check(16'(rd), 16'(v[i]));
                check(16'(ok), 16'h0001);
            end
            check(16'(synth_control.synth_one_enable), 16'(v[0][0]));
            check(16'(synth_control.synth_two_enable), 16'(v[1][0]));
            check(16'(synth_control.input_multiple_n), 16'(v[1][4:1]));
            check(16'(synth_control.out1_factor), 16'(v[2]));
            check(16'(synth_control.out2_factor), 16'(v[3]));
            check(16'({synth_control.frame_sync_drive_enable, synth_control.first_output_drive_enable,
                       synth_control.second_output_drive_enable, synth_control.lock_indicator_select}),
                  16'(v[4]));
            check(16'(synth_control.ref_multiple), p ? 16'h0020 : 16'h0001);
        end
    endtask : t_regs

    // Codes 1110 and 1111 are never written
    task automatic t_modes;
        for (int s = 0; s < 2; s++) begin
            slave_config <= 1'(s);
            for (int c = 0; c < 14; c++) begin
                wr(4'h0, {3'h0, 4'(c), 1'b1});
                check(16'(operating_mode_code), 16'(c));
                if (s == 0) check(16'({mode_decode.ref_kind, mode_decode.out1_kind}),
                                  16'({REF_M[c], OUT1_M[c]}));
                else check(16'(mode_decode.ref_kind), c == 13 ? 16'h0003 : 16'h0006);
            end
        end
        slave_config <= 1'b0;
    endtask : t_modes

    task automatic t_high_speed;
        wr(4'h0, 8'h1B);
        for (int i = 0; i < 4; i++) begin
            wr(4'h2, 8'(1 << i));
            check(16'(synth_control.out1_multiple_m), 16'(1 << i));
        end
    endtask : t_high_speed

    // Address with A3 set must not alias onto register 3
    task automatic t_refused;
        wr(4'h3, 8'h0A);
        wr(4'hB, 8'h15);
        check(16'(synth_control.out2_factor), 16'h000A);
        rdreg(4'hB);
        check(16'(rd), 16'h0000);
    endtask : t_refused

    initial begin
        repeat (100000) @(posedge sys_clk);
        errors++;
        conclude();
    end

    initial begin
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (4) @(posedge sys_clk);
        t_regs();
        t_modes();
        t_high_speed();
        t_refused();
        conclude();
    end
endmodule : synth_command_registers_tb
`default_nettype wire

//--- hdl/mode_decoder.sv
// Purpose: Decodes the operating mode code into reference and output kinds
// Assumes: Slave selects the slave table
// Notes: Purely combinational
`timescale 1ns/1ps
`default_nettype none
module mode_decoder
    import synth_cmd_pkg::*;
(
    input  wire synth_cmd_pkg::operating_mode_code_type code,
    input  wire logic                                  slave_config,
    output synth_cmd_pkg::mode_decode_type             decode
);
    always_comb begin
        decode = '{1'b0, 1'b0, 1'b0, 1'b0, ref_none, out_none, out_none};
        case (code)
            mode_fwd_t1_5656, mode_fwd_e1_5656: begin
                decode.fwd_family = 1'b1;
                decode.out1_kind  = out_k_56k;
                decode.out2_kind  = out_k_56k;
            end
            mode_fwd_t1_5664, mode_fwd_e1_5664: begin
                decode.fwd_family = 1'b1;
                decode.out1_kind  = out_k_56k;
                decode.out2_kind  = out_k_64k;
            end
            mode_fwd_t1_6464, mode_fwd_e1_6464: begin
                decode.fwd_family = 1'b1;
                decode.out1_kind  = out_k_64k;
                decode.out2_kind  = out_k_64k;
            end
            mode_rev_56, mode_rev_64, mode_frac_56_t1e1: begin
                decode.out1_kind = out_t1;
                decode.out2_kind = out_e1;
            end
            mode_e1_to_t1: begin
                decode.fwd_family = ~slave_config;
                decode.out1_kind  = slave_config ? out_k_56k : out_t1;
                decode.out2_kind  = slave_config ? out_k_64k : out_t1;
            end
            mode_frac_56_t1t1: begin
                decode.out1_kind = out_t1;
                decode.out2_kind = out_t1;
            end
            mode_frac_64_e1t1: begin
                decode.out1_kind = out_e1;
                decode.out2_kind = out_t1;
            end
            mode_frac_64_e1e1: begin
                decode.out1_kind = out_e1;
                decode.out2_kind = out_e1;
            end
            mode_high_speed: begin
                decode.high_speed = 1'b1;
                decode.out1_kind  = out_m_e1;
                decode.out2_kind  = out_m_e1;
            end
            default: begin
                decode.reserved_code = 1'b1;
            end
        endcase
        // Fractional codes in master only; slave treats them as plain reverse
        decode.frac_family = ~slave_config && (code >= mode_frac_56_t1e1)
                             && (code <= mode_frac_64_e1e1);
        case (code)
            mode_fwd_t1_5656, mode_fwd_t1_5664, mode_fwd_t1_6464: decode.ref_kind = ref_n_t1;
            mode_fwd_e1_5656, mode_fwd_e1_5664, mode_fwd_e1_6464,
            mode_e1_to_t1:                                         decode.ref_kind = ref_n_e1;
            mode_rev_56:                                           decode.ref_kind = ref_56k;
            mode_rev_64, mode_high_speed:                          decode.ref_kind = ref_64k;
            mode_frac_56_t1e1, mode_frac_56_t1t1:                  decode.ref_kind = ref_p_56k;
            mode_frac_64_e1t1, mode_frac_64_e1e1:                  decode.ref_kind = ref_p_64k;
            default:                                               decode.ref_kind = ref_none;
        endcase
        if (slave_config && !decode.high_speed && !decode.reserved_code) begin
            decode.ref_kind = ref_8k;
        end
    end
endmodule : mode_decoder
`default_nettype wire

//--- hdl/pin_sync.sv
// Purpose: Three-stage input synchroniser with agreement filter
// Assumes: Inputs are asynchronous pins
// Notes: Output changes once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             sys_clk,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] pin_in,
    output logic      [WIDTH-1:0] pin_out
);
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
    logic [WIDTH-1:0] stage3;

    always_ff @(posedge sys_clk) begin
        stage1 <= pin_in;
        stage2 <= stage1;
        stage3 <= stage2;
    end

    genvar i;
    generate
        for (i = 0; i < WIDTH; i++) begin : g_agree
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    pin_out[i] <= 1'b1;
                end else if (stage2[i] == stage3[i]) begin
                    pin_out[i] <= stage3[i];
                end
            end
        end
    endgenerate
endmodule : pin_sync
`default_nettype wire

//--- hdl/synth_command_registers.sv
// Purpose: Command register bank of a dual synthesizer behind a four-wire serial port
// Assumes: Serial pins are asynchronous to sys_clk and far slower (one bit per several clocks)
// Notes: Serial clock is sampled as a pin, not used as a clock
`timescale 1ns/1ps
`default_nettype none
`include "synth_cmd_map.svh"
module synth_command_registers
    import synth_cmd_pkg::*;
#(
    parameter int REG_WIDTH = 5
) (
    input  wire logic                          sys_clk,
    input  wire logic                          rst,
    input  wire logic                          chip_select_low,
    input  wire logic                          serial_clock,
    input  wire logic                          serial_in,
    output logic                               serial_out,
    output logic                               serial_out_en,
    input  wire logic                          slave_config,
    output synth_cmd_pkg::operating_mode_code_type operating_mode_code,
    output synth_cmd_pkg::mode_decode_type     mode_decode,
    output synth_cmd_pkg::synth_control_type   synth_control
);
    import synth_cmd_pkg::*;

    // ---------------------------------------------------------------
    // Pin synchronisation
    // ---------------------------------------------------------------
    logic [2:0] pins_sync;
    pin_sync #(.WIDTH(3)) u_pin_sync (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pin_in  ({chip_select_low, serial_clock, serial_in}),
        .pin_out (pins_sync)
    );

    wire cs_active = ~pins_sync[2];
    wire sclk_now  = pins_sync[1];
    wire sdi_now   = pins_sync[0];

    logic sclk_prev;
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            sclk_prev <= 1'b0;
        end else begin
            sclk_prev <= sclk_now;
        end
    end

    wire sclk_rise = cs_active & sclk_now & ~sclk_prev;
    wire sclk_fall = cs_active & ~sclk_now & sclk_prev;

    // ---------------------------------------------------------------
    // Serial frame state
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        st_idle   = 2'b00,
        st_header = 2'b01,
        st_read   = 2'b10,
        st_write  = 2'b11
    } frame_state_type;

    frame_state_type        state;
    frame_state_type        next_state;
    logic [3:0]             bit_count;
    logic [3:0]             next_bit_count;
    logic [7:0]             header;
    logic [7:0]             wr_shift;
    logic [REG_WIDTH-1:0]   rd_shift;
    logic [REG_WIDTH-1:0]   regs [`REG_COUNT];

    // Header arrives LSB first into bit 0: direction, A0..A3, zeros, don't care
    wire       hdr_read  = header[0];
    wire [3:0] hdr_addr  = header[4:1];
    wire [2:0] reg_index = hdr_addr[2:0];
    // Addresses above 0x07 or with nonzero padding bits hit no register
    wire       addr_ok   = (hdr_addr[3] == 1'b0);
    wire       header_done = (state == st_header) && sclk_rise
                             && (bit_count == `HDR_BITS - 4'h1);
    wire [7:0] header_full = {sdi_now, header[7:1]};
    wire       full_read   = header_full[0];
    wire       full_ok     = (header_full[4] == 1'b0) && (header_full[6:5] == 2'b00);
    wire [2:0] full_index  = header_full[3:1];
    wire       write_done = (state == st_write) && sclk_rise
                            && (bit_count == `WR_DATA_BITS - 4'h1);
    wire [7:0] wr_full    = {sdi_now, wr_shift[7:1]};

    always_comb begin
        next_state     = state;
        next_bit_count = bit_count;
        case (state)
            st_idle: begin
                next_bit_count = 4'h0;
                if (cs_active) begin
                    next_state = st_header;
                end
            end
            st_header: begin
                if (sclk_rise) begin
                    next_bit_count = bit_count + 4'h1;
                end
                if (header_done) begin
                    next_bit_count = 4'h0;
                    next_state     = full_read ? st_read : st_write;
                end
            end
            st_read: begin
                if (sclk_fall) begin
                    next_bit_count = bit_count + 4'h1;
                end
            end
            st_write: begin
                if (sclk_rise) begin
                    next_bit_count = bit_count + 4'h1;
                end
                if (write_done) begin
                    next_state = st_idle;
                end
            end
            default: begin
                next_state = st_idle;
            end
        endcase
        // Deselect aborts any frame; a half-written word is discarded
        if (!cs_active) begin
            next_state = st_idle;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state     <= st_idle;
            bit_count <= 4'h0;
        end else begin
            state     <= next_state;
            bit_count <= next_bit_count;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            header <= 8'h00;
        end else if (state == st_header && sclk_rise) begin
            header <= header_full;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            wr_shift <= 8'h00;
        end else if (state == st_write && sclk_rise) begin
            wr_shift <= wr_full;
        end
    end

    // ---------------------------------------------------------------
    // Register storage
    // ---------------------------------------------------------------
    // Eight data bits are clocked in; the register keeps the low five
    genvar r;
    generate
        for (r = 0; r < `REG_COUNT; r++) begin : g_reg
            always_ff @(posedge sys_clk) begin
                if (rst) begin
                    regs[r] <= `REG_RESET_VALUE;
                end else if (write_done && addr_ok && !hdr_read
                             && header[6:5] == 2'b00 && reg_index == 3'(r)) begin
                    regs[r] <= wr_full[REG_WIDTH-1:0];
                end
            end
        end
    endgenerate

    // ---------------------------------------------------------------
    // Read path
    // ---------------------------------------------------------------
    // Data is loaded at header end and shifted out on falling serial clock
    wire [REG_WIDTH-1:0] read_word = full_ok ? regs[full_index] : '0;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_shift <= '0;
        end else if (header_done && full_read) begin
            rd_shift <= read_word;
        end else if (state == st_read && sclk_fall && bit_count != 4'h0) begin
            rd_shift <= {1'b0, rd_shift[REG_WIDTH-1:1]};
        end
    end

    // Driver turns on at the first falling edge after the header and stays for five bits
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end else if (state == st_read && sclk_fall && bit_count < `HDR_DATA_BITS) begin
            serial_out    <= (bit_count == 4'h0) ? rd_shift[0] : rd_shift[1];
            serial_out_en <= 1'b1;
        end else if (state != st_read
                     || (sclk_fall && bit_count >= `HDR_DATA_BITS)) begin
            serial_out    <= 1'b0;
            serial_out_en <= 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // Control fields
    // ---------------------------------------------------------------
    wire [4:0] reg0 = regs[`REG_MODE_SYNTH1];
    wire [4:0] reg1 = regs[`REG_INMULT_SYNTH2];
    wire [4:0] reg2 = regs[`REG_OUT1_FACTOR];
    wire [4:0] reg3 = regs[`REG_OUT2_FACTOR];
    wire [4:0] reg4 = regs[`REG_DRIVE_LOCK];

    assign operating_mode_code = operating_mode_code_type'(reg0[4:1]);

    mode_decoder u_mode_decoder (
        .code         (operating_mode_code),
        .slave_config (slave_config),
        .decode       (mode_decode)
    );

    // Field value 0 stands for the top multiple (16 or 32), giving 1..16 and 1..32
    wire [5:0] n_value = (reg1[4:1] == 4'h0) ? 6'd16 : {2'b00, reg1[4:1]};
    wire [5:0] p_value = (reg2 == 5'h00) ? 6'd32 : {1'b0, reg2};

    always_comb begin
        synth_control.synth_one_enable  = reg0[`BIT_SYNTH_ENABLE];
        synth_control.synth_two_enable  = reg1[`BIT_SYNTH_ENABLE];
        synth_control.input_multiple_n  = reg1[4:1];
        synth_control.out1_factor       = reg2;
        synth_control.out2_factor       = reg3;
        synth_control.ref_multiple      = 6'd1;
        if (mode_decode.fwd_family || operating_mode_code == mode_e1_to_t1) begin
            synth_control.ref_multiple  = n_value;
        end else if (mode_decode.frac_family) begin
            synth_control.ref_multiple  = p_value;
        end
        // Only 1, 2, 4 and 8 are legal; anything else falls back to 1
        case (reg2)
            5'h01, 5'h02, 5'h04, 5'h08: synth_control.out1_multiple_m = reg2;
            default:                    synth_control.out1_multiple_m = 5'h01;
        endcase
        synth_control.frame_sync_drive_enable    = reg4[`BIT_FRAME_SYNC_EN];
        synth_control.first_output_drive_enable  = reg4[`BIT_OUT1_DRIVE_EN];
        synth_control.second_output_drive_enable = reg4[`BIT_OUT2_DRIVE_EN];
        synth_control.lock_indicator_select      = reg4[1:0];
    end
endmodule : synth_command_registers
`default_nettype wire

//--- include/synth_cmd_map.svh
// Purpose: Offsets, field positions, reset values and timing counts of the command registers
// Assumes: Included by bare name; definitions only
// Notes on behaviour
// - Eight five-bit read/write command registers sit at addresses 0x00 to 0x07, the last three all reserved.
// - In master, mode codes 0000-0010 are forward master on an N x 1.544MHz reference and 0100-0110 on N x 2.048MHz.
// - In master, code 0011 is reverse master from 56kHz and 0111 from 64kHz, giving 1.544MHz and 2.048MHz.
// - Code 1000 is E1-to-T1 forward master giving 1.544MHz twice; code 1101 is high-speed reverse from 64kHz.
// - Codes 1001-1100 are fractional reverse master on a P x 56kHz or P x 64kHz reference.
// - In slave, codes 0000-1100 expect an 8kHz reference, while 1101 stays high-speed reverse on 64kHz.
// - Bit 0 of register 0x00 enables the first synthesizer loop when set.
// - Bit 0 of register 0x01 enables the second synthesizer loop when set.
// - Bits 4..1 of register 0x01 give the forward reference multiple N, at most 16.
// - Register 0x02 gives the first output multiple K in forward master, up to 32.
// - In fractional reverse master, register 0x02 gives the reference multiple P, up to 32.
// - In high-speed reverse, register 0x02 is multiplier M, which the controller sets only to 1, 2, 4 or 8.
// - A serial access opens with a direction bit (1 read), four address bits LSB first, two zeros and a don't-care bit.
// - Register 0x03 gives the second output multiple K in forward master, up to 32.
// - Each driver enable bit of register 0x04 turns its output driver on when set.
`ifndef SYNTH_CMD_MAP_SVH
`define SYNTH_CMD_MAP_SVH

`define REG_MODE_SYNTH1      3'h0
`define REG_INMULT_SYNTH2    3'h1
`define REG_OUT1_FACTOR      3'h2
`define REG_OUT2_FACTOR      3'h3
`define REG_DRIVE_LOCK       3'h4
`define REG_COUNT            8
`define REG_RESET_VALUE      5'h00

`define BIT_SYNTH_ENABLE     0
`define BIT_FRAME_SYNC_EN    4
`define BIT_OUT1_DRIVE_EN    3
`define BIT_OUT2_DRIVE_EN    2

`define HDR_BITS             4'h8
`define HDR_DATA_BITS        4'h5
`define WR_DATA_BITS         4'h8

`endif

//--- include/synth_cmd_pkg.sv
// Purpose: Types shared by the command register bank
// Assumes: Nothing beyond SystemVerilog packages
// Notes: Mode codes are the four-bit operating mode field
package synth_cmd_pkg;

    typedef enum logic [3:0] {
        mode_fwd_t1_5656   = 4'h0,
        mode_fwd_t1_5664   = 4'h1,
        mode_fwd_t1_6464   = 4'h2,
        mode_rev_56        = 4'h3,
        mode_fwd_e1_5656   = 4'h4,
        mode_fwd_e1_5664   = 4'h5,
        mode_fwd_e1_6464   = 4'h6,
        mode_rev_64        = 4'h7,
        mode_e1_to_t1      = 4'h8,
        mode_frac_56_t1e1  = 4'h9,
        mode_frac_56_t1t1  = 4'hA,
        mode_frac_64_e1t1  = 4'hB,
        mode_frac_64_e1e1  = 4'hC,
        mode_high_speed    = 4'hD,
        mode_rsvd_e        = 4'hE,
        mode_rsvd_f        = 4'hF
    } operating_mode_code_type;

    typedef enum logic [2:0] {
        ref_n_t1   = 3'h0,
        ref_n_e1   = 3'h1,
        ref_56k    = 3'h2,
        ref_64k    = 3'h3,
        ref_p_56k  = 3'h4,
        ref_p_64k  = 3'h5,
        ref_8k     = 3'h6,
        ref_none   = 3'h7
    } reference_kind_type;

    typedef enum logic [2:0] {
        out_k_56k  = 3'h0,
        out_k_64k  = 3'h1,
        out_t1     = 3'h2,
        out_e1     = 3'h3,
        out_m_e1   = 3'h4,
        out_none   = 3'h5
    } output_kind_type;

    typedef struct packed {
        logic                    fwd_family;
        logic                    frac_family;
        logic                    high_speed;
        logic                    reserved_code;
        reference_kind_type      ref_kind;
        output_kind_type         out1_kind;
        output_kind_type         out2_kind;
    } mode_decode_type;

    typedef struct packed {
        logic       synth_one_enable;
        logic       synth_two_enable;
        logic [3:0] input_multiple_n;
        logic [4:0] out1_factor;
        logic [4:0] out2_factor;
        logic [5:0] ref_multiple;
        logic [4:0] out1_multiple_m;
        logic       frame_sync_drive_enable;
        logic       first_output_drive_enable;
        logic       second_output_drive_enable;
        logic [1:0] lock_indicator_select;
    } synth_control_type;

endpackage : synth_cmd_pkg
